/* rtl/supervisor_reset_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// [RULE_01] reset held low while supply low
// [RULE_02] reset stays low 200 ms after supply recovers
// [RULE_03] active-high reset is exact inverse
// [RULE_04] manual request low asserts reset, debounced
// [RULE_05] stretch counts from last cause clearing
// [RULE_06] no kick for 1.60 s drives alarm low
// [RULE_07] every kick edge restarts watchdog timer
// [RULE_08] watchdog held cleared during reset
// [RULE_09] alarm stays low until kick or reset; code also clears it while kick floats
// [RULE_10] alarm forced low while supply low
// [RULE_11] alarm returns high when supply recovers
// [RULE_12] floating kick disables watchdog timeout
// [RULE_13] timeout never asserts reset by itself
// [RULE_14] fail output follows sense comparator
// [RULE_15] host toggles kick within 1.60 s
// [RULE_16] both times derived from clock parameter
// [RULE_17] analog results enter through synchronisers
module supervisor_reset_watchdog #(
    parameter int unsigned STRETCH_CYCLES = supervisor_pkg::STRETCH_CYC,
    parameter int unsigned TIMEOUT_CYCLES = supervisor_pkg::TIMEOUT_CYC
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // analog front end results and pins
    input wire logic supplyLow,
    input wire logic manual_reset_req_n,
    input wire logic kick_input,
    input wire logic kickFloat,
    input wire logic supply_sense_in,
    // outputs to host
    output logic resetOut_n,
    output logic resetOutHigh,
    output logic watchdog_alarm_n,
    output logic supply_fail_n
);
    // two-stage synchronisers, reset to safe values
    supervisor_pkg::front_type syncA_ff, syncB_ff, nxt_syncA, nxt_syncB;
    supervisor_pkg::front_type front;
    // reset sequencer state
    supervisor_pkg::rst_state_type rstState_ff, nxt_rstState;
    logic [supervisor_pkg::CNT_W-1:0] stretchCnt_ff, nxt_stretchCnt;
    // watchdog state
    logic [supervisor_pkg::CNT_W-1:0] wdCnt_ff, nxt_wdCnt;
    logic kickPrev_ff, nxt_kickPrev;
    logic timedOut_ff, nxt_timedOut;
    logic failN_ff, nxt_failN;
    logic cause;
    logic kickEdge;

    // sampled inputs, all from outside the clock domain
    always_comb begin
        nxt_syncA.supplyLow = supplyLow;
        nxt_syncA.manualReqN = manual_reset_req_n;
        nxt_syncA.kick = kick_input;
        nxt_syncA.kickFloat = kickFloat;
        nxt_syncA.senseBelow = supply_sense_in;
        nxt_syncB = syncA_ff;
    end

    // synchroniser flops; stage A read only by stage B
    // reset image: supply low, no manual request, kick low, not floating,
    // sense above reference; kick low matches kickPrev_ff so that no
    // false kick edge appears right after reset
    always_ff @(posedge clk or negedge rst_n) begin // see [RULE_17]
        if (!rst_n) begin
            syncA_ff <= 5'h18;
            syncB_ff <= 5'h18;
        end else if (clkEn) begin
            syncA_ff <= nxt_syncA;
            syncB_ff <= nxt_syncB;
        end
    end
    assign front = syncB_ff;

    // any reset cause; watchdog is not one of them
    // a user wanting reset on timeout wires the alarm back into the
    // manual request pin outside the block
    assign cause = front.supplyLow | ~front.manualReqN; // see [RULE_13]

    // reset sequencer: hold while cause, then stretch
    always_comb begin
        nxt_rstState = rstState_ff;
        nxt_stretchCnt = stretchCnt_ff;
        unique case (rstState_ff)
            supervisor_pkg::ST_HOLD: begin
                if (cause) begin
                    // bounces restart the stretch: see [RULE_04]
                    nxt_stretchCnt = '0; // see [RULE_01]
                end else if (stretchCnt_ff >= STRETCH_CYCLES - 1) begin
                    nxt_rstState = supervisor_pkg::ST_RUN; // see [RULE_02]
                end else begin
                    // counts from the last cause to clear: see [RULE_05]
                    nxt_stretchCnt = stretchCnt_ff + 1'b1;
                end
            end
            supervisor_pkg::ST_RUN: begin
                if (cause) begin
                    nxt_rstState = supervisor_pkg::ST_HOLD;
                    nxt_stretchCnt = '0;
                end
            end
        endcase
    end

    // sequencer registers; reset starts in hold (power-on stretch)
    always_ff @(posedge clk or negedge rst_n) begin // see [RULE_16]
        if (!rst_n) begin
            rstState_ff <= supervisor_pkg::ST_HOLD;
            stretchCnt_ff <= '0;
        end else if (clkEn) begin
            rstState_ff <= nxt_rstState;
            stretchCnt_ff <= nxt_stretchCnt;
        end
    end

    // both reset polarities from one term, run state gated by cause, never skewed
    assign resetOut_n = (rstState_ff == supervisor_pkg::ST_RUN) & ~cause;
    assign resetOutHigh = ~resetOut_n; // see [RULE_03]

    // kick edge detect on synchronised level
    // both polarities count, so a stuck-high or stuck-low host is caught
    assign kickEdge = front.kick ^ kickPrev_ff;

    // watchdog next state
    always_comb begin
        nxt_kickPrev = front.kick;
        nxt_wdCnt = wdCnt_ff;
        nxt_timedOut = timedOut_ff;
        if (!resetOut_n || front.kickFloat) begin
            // cleared during reset, idle while floating
            nxt_wdCnt = '0; // see [RULE_08] see [RULE_12]
            nxt_timedOut = 1'b0;
        end else if (kickEdge) begin
            nxt_wdCnt = '0; // see [RULE_07]
            nxt_timedOut = 1'b0; // see [RULE_09]
        end else if (wdCnt_ff >= TIMEOUT_CYCLES - 1) begin
            nxt_timedOut = 1'b1; // see [RULE_06]
        end else begin
            nxt_wdCnt = wdCnt_ff + 1'b1;
        end
        // comparator result to fail output
        nxt_failN = ~front.senseBelow; // see [RULE_14]
    end

    // watchdog and fail registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdCnt_ff <= '0;
            kickPrev_ff <= 1'b0;
            timedOut_ff <= 1'b0;
            failN_ff <= 1'b1;
        end else if (clkEn) begin
            wdCnt_ff <= nxt_wdCnt;
            kickPrev_ff <= nxt_kickPrev;
            timedOut_ff <= nxt_timedOut;
            failN_ff <= nxt_failN;
        end
    end

    // alarm: timeout or supply low; high again once both gone
    assign watchdog_alarm_n = ~(timedOut_ff | front.supplyLow); // see [RULE_10] see [RULE_11]
    assign supply_fail_n = failN_ff;

    // assertions
    AST_SUPPLY_HOLDS_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        front.supplyLow |-> !resetOut_n) // see [RULE_01]
        else $error("reset released while supply low");
    AST_INVERSE: assert property (@(posedge clk) disable iff (!rst_n)
        resetOutHigh == !resetOut_n) // see [RULE_03]
        else $error("reset outputs not complementary");
    AST_MANUAL_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        !front.manualReqN |-> !resetOut_n) // see [RULE_04]
        else $error("manual request did not assert reset");
    AST_STRETCH: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && cause) ##1 !cause |-> !resetOut_n) // see [RULE_02]
        else $error("reset released without stretch");
    AST_NO_EARLY_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(resetOut_n) |-> $past(stretchCnt_ff) >= STRETCH_CYCLES - 1) // see [RULE_05]
        else $error("reset released before stretch ended");
    AST_KICK_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && resetOut_n && kickEdge) |=> wdCnt_ff == 0 && !timedOut_ff) // see [RULE_07]
        else $error("kick edge did not clear watchdog");
    AST_WD_HELD: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !resetOut_n) |=> wdCnt_ff == 0) // see [RULE_08]
        else $error("watchdog counted during reset");
    AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(timedOut_ff) |-> $past(wdCnt_ff) >= TIMEOUT_CYCLES - 1) // see [RULE_06]
        else $error("timeout fired early");
    AST_ALARM_SUPPLY: assert property (@(posedge clk) disable iff (!rst_n)
        front.supplyLow |-> !watchdog_alarm_n) // see [RULE_10]
        else $error("alarm high while supply low");
    AST_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && front.kickFloat) |=> !timedOut_ff) // see [RULE_12]
        else $error("timeout while kick floating");
    AST_FAIL: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> supply_fail_n == !$past(front.senseBelow)) // see [RULE_14]
        else $error("fail output wrong");
    COV_RELEASE: cover property (@(posedge clk) $rose(resetOut_n));
    COV_TIMEOUT: cover property (@(posedge clk) $rose(timedOut_ff));
    AST_ALARM_HELD: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && timedOut_ff && resetOut_n && !kickEdge && !front.kickFloat)
        |=> timedOut_ff) // see [RULE_09]
        else $error("alarm dropped without kick or reset");
    AST_ALARM_BACK: assert property (@(posedge clk) disable iff (!rst_n)
        ($fell(front.supplyLow) && !timedOut_ff) |-> watchdog_alarm_n) // see [RULE_11]
        else $error("alarm stayed low after supply recovered");
    AST_WD_NO_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        (timedOut_ff && !cause && rstState_ff == supervisor_pkg::ST_RUN)
        |-> resetOut_n) // see [RULE_13]
        else $error("timeout pulled reset low");
    // covers for the main scenarios
    COV_MANUAL: cover property (@(posedge clk) $fell(front.manualReqN));
    COV_FLOAT: cover property (@(posedge clk) $rose(front.kickFloat));
endmodule
`default_nettype wire

/* rtl/supervisor_pkg.sv */
`default_nettype none
package supervisor_pkg;
    // internal timebase
    localparam int unsigned CLK_HZ = 25_000_000;
    // reset stretch after last cause clears, in milliseconds
    localparam int unsigned STRETCH_MS = 200;
    // watchdog timeout, in milliseconds (1.60 s)
    localparam int unsigned TIMEOUT_MS = 1600;
    // derived cycle counts (exact at 25 MHz)
    localparam int unsigned STRETCH_CYC = (CLK_HZ / 1000) * STRETCH_MS;
    localparam int unsigned TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    // counter width large enough for both counts
    localparam int unsigned CNT_W = 32;

    // synchronised front-end inputs travel together
    typedef struct packed {
        logic supplyLow;
        logic manualReqN;
        logic kick;
        logic kickFloat;
        logic senseBelow;
    } front_type;

    // reset sequencer states
    typedef enum logic [0:0] {
        ST_HOLD = 1'b0,
        ST_RUN = 1'b1
    } rst_state_type;
endpackage
`default_nettype wire

/* verif/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter int unsigned KICK_GAP = 30
) (
    // clock and reset seen by the host
    input wire logic clk,
    input wire logic resetOut_n,
    // software loop alive
    input wire logic active,
    // kick line
    output logic kick_input
);
    int gap; // cycles since last toggle
    // software toggles kick well inside the timeout, only out of reset
    initial begin
        kick_input = 1'b0;
        gap = 0;
        forever begin
            @(negedge clk);
            gap = gap + 1;
            if (active && resetOut_n && gap >= KICK_GAP) begin
                kick_input = ~kick_input;
                gap = 0;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/supervisor_reset_watchdog_test.sv */
`timescale 1ns/1ps
`default_nettype none
module supervisor_reset_watchdog_test;
    localparam int unsigned ST = 20; // shortened stretch
    localparam int unsigned TO = 50; // shortened timeout
    logic clk, rst_n, supplyLow, manualReqN, kickFloat, senseIn, hostOn;
    logic kick, resetOut_n, resetOutHigh, alarm_n, fail_n;
    int mismatches, n_tests;
    supervisor_reset_watchdog #(.STRETCH_CYCLES(ST), .TIMEOUT_CYCLES(TO))
    i_dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .supplyLow(supplyLow),
        .manual_reset_req_n(manualReqN), .kick_input(kick),
        .kickFloat(kickFloat), .supply_sense_in(senseIn),
        .resetOut_n(resetOut_n), .resetOutHigh(resetOutHigh),
        .watchdog_alarm_n(alarm_n), .supply_fail_n(fail_n));
    host_model #(.KICK_GAP(30)) i_host (.clk(clk), .resetOut_n(resetOut_n),
        .active(hostOn), .kick_input(kick));
    // free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? resetOut_n : (w == 1 ? alarm_n : fail_n);
    endfunction
    // bounded wait, the limit running out shows up as a mismatch
    task automatic waitFor(string nm, int w, logic exp, int lim);
        for (int i = 0; i < lim && sig(w) !== exp; i++) @(negedge clk);
        chk(nm, exp, sig(w));
    endtask
    task automatic t_power();
        supplyLow = 1'b1;
        cyc(4);
        chk("reset", 1'b0, resetOut_n);
        chk("resetHigh", 1'b1, resetOutHigh);
        chk("alarm", 1'b0, alarm_n);
        supplyLow = 1'b0;
        cyc(ST - 4);
        chk("stretch", 1'b0, resetOut_n);
        waitFor("release", 0, 1'b1, 12);
        chk("resetHigh", 1'b0, resetOutHigh);
        chk("alarmBack", 1'b1, alarm_n);
        cyc(TO - 8);
        chk("timerCleared", 1'b1, alarm_n);
    endtask
    task automatic t_manual();
        // bouncing request must give one reset
        for (int i = 0; i < 3; i++) begin
            manualReqN = 1'b0;
            cyc(2);
            manualReqN = 1'b1;
            cyc(1);
        end
        chk("manReset", 1'b0, resetOut_n);
        cyc(ST - 4);
        chk("manStretch", 1'b0, resetOut_n);
        waitFor("manRelease", 0, 1'b1, 12);
        // overlapping causes, manual clears last
        supplyLow = 1'b1;
        manualReqN = 1'b0;
        cyc(5);
        supplyLow = 1'b0;
        cyc(10);
        manualReqN = 1'b1;
        cyc(ST - 4);
        chk("lastCause", 1'b0, resetOut_n);
        waitFor("lastRelease", 0, 1'b1, 12);
    endtask
    task automatic t_dog();
        hostOn = 1'b1;
        cyc(TO * 4);
        chk("alarmKicked", 1'b1, alarm_n);
        @(kick);
        hostOn = 1'b0;
        cyc(TO - 8);
        chk("alarmEarly", 1'b1, alarm_n);
        waitFor("alarmLate", 1, 1'b0, 20);
        cyc(TO * 2);
        chk("alarmHeld", 1'b0, alarm_n);
        chk("noReset", 1'b1, resetOut_n);
        hostOn = 1'b1;
        waitFor("alarmCleared", 1, 1'b1, 40);
        @(kick);
        hostOn = 1'b0;
    endtask
    task automatic t_float();
        kickFloat = 1'b1;
        cyc(TO * 3);
        chk("floatQuiet", 1'b1, alarm_n);
        supplyLow = 1'b1;
        cyc(4);
        chk("floatLowLine", 1'b0, alarm_n);
        supplyLow = 1'b0;
        waitFor("floatRelease", 0, 1'b1, ST + 12);
        // comparator result both ways
        for (int v = 1; v >= 0; v--) begin
            senseIn = v[0];
            cyc(4);
            chk("fail", ~v[0], fail_n);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard, far beyond the under one thousand cycles needed
    initial begin
        #(40 * 20000);
        mismatches++;
        give_verdict();
    end
    initial begin
        {supplyLow, kickFloat, senseIn, hostOn} = 4'h0;
        {rst_n, manualReqN, mismatches, n_tests} = '0;
        manualReqN = 1'b1;
        cyc(20);
        rst_n = 1'b1;
        waitFor("powerOn", 0, 1'b1, ST + 12);
        t_power();
        t_manual();
        t_dog();
        t_float();
        give_verdict();
    end
endmodule
`default_nettype wire
